// ---- hdl/alm_axis_limit_monitor.sv ----
// Purpose: Axis limit, overrun and stop monitoring for a servo axis
// Assumes: Position datapath on clk_in; switch pins asynchronous
// Notes:   Status and error memory clear on re-referencing or reset
// What this block does
// - Axis position is a signed 32-bit count
// - Crossing range end sets overrun, wraps area
// - Overrun reported in status bit 2
// - Overrun logs fault code in error memory
// - Overrun sticky until referencing or power cycle
// - Overrun detection off in absolute point-to-point
// - Relative point-to-point zeroes dimension in the same cycle as tripping
// - Overrun clears referenced bit 5 of extended status
// - Teach-in refused after overrun
// - Soft limits checked only when enabled, reset off
// - Soft limits compare the controller setpoint
// - Soft trips flagged in status bits 5, 6
// - Bit 7 halt, bit 15 amplifier off
// - Hardware limits stop motor during movement
// - Stop input quick-stops until release, ack, command
// - Enable mask gates limit, stop, home inputs
// - Level mask selects active level per input
// - Home switch acts as stop except homing
`timescale 1ns/10ps
`default_nettype none
module alm_axis_limit_monitor (
   input  wire logic                  clk_in,
   input  wire logic                  rst_b_in,
   // Register port
   input  wire logic [2:0]            reg_addr_in,
   input  wire logic [31:0]           reg_wdata_in,
   input  wire logic                  reg_wr_in,
   input  wire logic                  reg_rd_in,
   output logic      [31:0]           reg_rdata_out,
   // Position datapath
   input  wire logic                  pos_step_in,
   input  wire logic                  pos_dir_neg_in,
   input  wire logic [31:0]           pos_setpoint_in,
   input  wire logic [1:0]            op_mode_in,
   input  wire logic                  moving_in,
   input  wire logic                  reference_done_in,
   input  wire logic                  new_move_cmd_in,
   input  wire logic                  quick_stop_ack_in,
   input  wire logic                  control_word_halt_in,
   input  wire logic                  amp_active_in,
   input  wire logic                  teach_req_in,
   // Switch pins
   input  wire logic                  positive_limit_input_in,
   input  wire logic                  negative_limit_input_in,
   input  wire logic                  stop_input_in,
   input  wire logic                  home_switch_in,
   // Results
   output logic      [31:0]           pos_actual_out,
   output logic                       motor_stop_out,
   output logic                       quick_stop_out,
   output logic                       limit_trip_out,
   output logic                       teach_accept_out,
   output logic                       teach_refused_out
);
   // Pins, decode and combinational results
   logic [3:0]         pins_sync;
   logic [3:0]         act;
   logic               trip_pos;
   logic               trip_neg;
   logic               limit_hit;
   logic               stop_req;
   logic               wrap;
   logic [31:0]        status_word;
   alm_pkg::alm_mode_t mode;
   // Position, overrun and error memory
   logic [31:0]        pos_r;
   logic [31:0]        pos_nxt;
   logic               ovr_r;
   logic               ovr_nxt;
   logic               refd_r;
   logic               refd_nxt;
   logic [19:0]        err_r;
   logic [19:0]        err_nxt;
   // Software-written settings
   logic [31:0]        slp_r;
   logic [31:0]        slp_nxt;
   logic [31:0]        sln_r;
   logic [31:0]        sln_nxt;
   logic [15:0]        sen_r;
   logic [15:0]        sen_nxt;
   logic [3:0]         ien_r;
   logic [3:0]         ien_nxt;
   logic [3:0]         ilv_r;
   logic [3:0]         ilv_nxt;
   // Quick stop, teach answer and read data
   logic               qs_r;
   logic               qs_nxt;
   logic               qs_acked_r;
   logic               qs_acked_nxt;
   logic               tr_ok_r;
   logic               tr_ok_nxt;
   logic               tr_no_r;
   logic               tr_no_nxt;
   logic [31:0]        rd_r;
   logic [31:0]        rd_nxt;

   // Pin synchroniser
   alm_sync #(
      .W (4)
   ) u_sync (
      .clk_in   (clk_in),
      .rst_b_in (rst_b_in),
      .d_in     ({home_switch_in, stop_input_in,
                  negative_limit_input_in, positive_limit_input_in}),
      .q_out    (pins_sync)
   );

   // Input is active when enabled and at selected level
   function automatic logic in_active(input logic pin, input logic en, input logic lvl);
      in_active = en & (pin == lvl);
   endfunction : in_active

   // Signed compare helper
   function automatic logic s_ge(input logic [31:0] a, input logic [31:0] b);
      s_ge = ($signed(a) >= $signed(b));
   endfunction : s_ge

   assign mode = alm_pkg::alm_mode_t'(op_mode_in);

   // Decoded switch activity
   always_comb begin
      act[alm_pkg::IN_POSITIVE_LIMIT_INPUT] = in_active(pins_sync[alm_pkg::IN_POSITIVE_LIMIT_INPUT],
                                        ien_r[alm_pkg::IN_POSITIVE_LIMIT_INPUT], ilv_r[alm_pkg::IN_POSITIVE_LIMIT_INPUT]);
      act[alm_pkg::IN_NEGATIVE_LIMIT_INPUT] = in_active(pins_sync[alm_pkg::IN_NEGATIVE_LIMIT_INPUT],
                                        ien_r[alm_pkg::IN_NEGATIVE_LIMIT_INPUT], ilv_r[alm_pkg::IN_NEGATIVE_LIMIT_INPUT]);
      act[alm_pkg::IN_STOP] = in_active(pins_sync[alm_pkg::IN_STOP],
                                        ien_r[alm_pkg::IN_STOP], ilv_r[alm_pkg::IN_STOP]);
      act[alm_pkg::IN_HOME] = in_active(pins_sync[alm_pkg::IN_HOME],
                                        ien_r[alm_pkg::IN_HOME], ilv_r[alm_pkg::IN_HOME]);
   end

   // Soft limit trips on setpoint
   assign trip_pos = sen_r[alm_pkg::SE_POS] & s_ge(pos_setpoint_in, slp_r);
   assign trip_neg = sen_r[alm_pkg::SE_NEG] & s_ge(sln_r, pos_setpoint_in);

   // Hardware limits stop the motor during motion
   assign limit_hit = moving_in & (act[alm_pkg::IN_POSITIVE_LIMIT_INPUT] | act[alm_pkg::IN_NEGATIVE_LIMIT_INPUT]);

   // Stop request from stop input or home switch
   assign stop_req = act[alm_pkg::IN_STOP] |
                     (act[alm_pkg::IN_HOME] & (mode != alm_pkg::ALM_MODE_HOMING));

   // Wrap condition at either end of range
   always_comb begin
      wrap = 1'b0;
      if (pos_step_in) begin
         if (!pos_dir_neg_in && pos_r == alm_pkg::POS_MAX) begin
            wrap = 1'b1;
         end else if (pos_dir_neg_in && pos_r == alm_pkg::POS_MIN) begin
            wrap = 1'b1;
         end
      end
   end

   // Position and overrun next state
   always_comb begin
      pos_nxt  = pos_r;
      ovr_nxt  = ovr_r;
      refd_nxt = refd_r;
      err_nxt  = err_r;
      if (pos_step_in) begin
         // Wrapping 32-bit count moves area by 2^32 units
         pos_nxt = pos_dir_neg_in ? pos_r - 32'h0000_0001
                                  : pos_r + 32'h0000_0001;
      end
      if (mode == alm_pkg::ALM_MODE_PTP_REL && wrap) begin
         pos_nxt = 32'h0000_0000;
      end
      if (reference_done_in) begin
         // Referencing defines the position anew from the setpoint
         pos_nxt  = pos_setpoint_in;
         ovr_nxt  = 1'b0;
         refd_nxt = 1'b1;
         err_nxt  = 20'h0_0000;
      end
      if (wrap && mode != alm_pkg::ALM_MODE_PTP_ABS) begin
         ovr_nxt  = 1'b1;
         refd_nxt = 1'b0;
         err_nxt  = alm_pkg::FAULT_OVERRUN;
      end
   end

   // Quick stop control
   always_comb begin
      qs_nxt       = qs_r;
      qs_acked_nxt = qs_acked_r;
      if (stop_req) begin
         qs_nxt       = 1'b1;
         qs_acked_nxt = 1'b0;
      end else if (qs_r) begin
         if (quick_stop_ack_in) begin
            qs_acked_nxt = 1'b1;
         end
         if ((qs_acked_r || quick_stop_ack_in) && new_move_cmd_in) begin
            qs_nxt       = 1'b0;
            qs_acked_nxt = 1'b0;
         end
      end
   end

   // Teach-in answer
   always_comb begin
      tr_ok_nxt = teach_req_in & ~ovr_r;
      tr_no_nxt = teach_req_in & ovr_r;
   end

   // Status word assembly; reserved bits zero
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[alm_pkg::ST_OVERRUN]  = ovr_r;
      status_word[alm_pkg::ST_SOFT_POS] = trip_pos;
      status_word[alm_pkg::ST_SOFT_NEG] = trip_neg;
      status_word[alm_pkg::ST_HALT]     = control_word_halt_in;
      status_word[alm_pkg::ST_AMP_OFF]  = ~amp_active_in;
   end

   // Register writes; status word ignores writes
   always_comb begin
      slp_nxt = slp_r;
      sln_nxt = sln_r;
      sen_nxt = sen_r;
      ien_nxt = ien_r;
      ilv_nxt = ilv_r;
      if (reg_wr_in) begin
         if (reg_addr_in == alm_pkg::REG_SOFT_POS) begin
            slp_nxt = reg_wdata_in; // relies on software ordering
         end else if (reg_addr_in == alm_pkg::REG_SOFT_NEG) begin
            sln_nxt = reg_wdata_in;
         end else if (reg_addr_in == alm_pkg::REG_SOFT_EN) begin
            sen_nxt = reg_wdata_in[15:0];
         end else if (reg_addr_in == alm_pkg::REG_IN_EN) begin
            ien_nxt = reg_wdata_in[3:0];
         end else if (reg_addr_in == alm_pkg::REG_IN_LEVEL) begin
            ilv_nxt = reg_wdata_in[3:0];
         end
      end
   end

   // Register reads
   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (reg_rd_in) begin
         if (reg_addr_in == alm_pkg::REG_STATUS) begin
            rd_nxt = status_word;
         end else if (reg_addr_in == alm_pkg::REG_SOFT_POS) begin
            rd_nxt = slp_r;
         end else if (reg_addr_in == alm_pkg::REG_SOFT_NEG) begin
            rd_nxt = sln_r;
         end else if (reg_addr_in == alm_pkg::REG_SOFT_EN) begin
            rd_nxt = {16'h0000, sen_r};
         end else if (reg_addr_in == alm_pkg::REG_IN_EN) begin
            rd_nxt = {28'h000_0000, ien_r};
         end else if (reg_addr_in == alm_pkg::REG_IN_LEVEL) begin
            rd_nxt = {28'h000_0000, ilv_r};
         end else if (reg_addr_in == alm_pkg::REG_XMODE) begin
            rd_nxt = 32'h0000_0000;
            rd_nxt[alm_pkg::XM_REFERENCED] = refd_r;
         end else if (reg_addr_in == alm_pkg::REG_ERROR) begin
            rd_nxt = {12'h000, err_r};
         end
      end
   end

   // Position and overrun registers
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pos_r      <= 32'h0000_0000;
         ovr_r      <= 1'b0;
         refd_r     <= 1'b0;
         err_r      <= 20'h0_0000;
      end else begin
         pos_r      <= pos_nxt;
         ovr_r      <= ovr_nxt;
         refd_r     <= refd_nxt;
         err_r      <= err_nxt;
      end
   end

   // Settings registers
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         slp_r      <= alm_pkg::SOFT_POS_RST;
         sln_r      <= alm_pkg::SOFT_NEG_RST;
         sen_r      <= alm_pkg::SOFT_EN_RST;
         ien_r      <= alm_pkg::IN_EN_RST;
         ilv_r      <= alm_pkg::IN_LEVEL_RST;
      end else begin
         slp_r      <= slp_nxt;
         sln_r      <= sln_nxt;
         sen_r      <= sen_nxt;
         ien_r      <= ien_nxt;
         ilv_r      <= ilv_nxt;
      end
   end

   // Quick stop registers
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         qs_r       <= 1'b0;
         qs_acked_r <= 1'b0;
      end else begin
         qs_r       <= qs_nxt;
         qs_acked_r <= qs_acked_nxt;
      end
   end

   // Teach answer registers
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         tr_ok_r    <= 1'b0;
         tr_no_r    <= 1'b0;
      end else begin
         tr_ok_r    <= tr_ok_nxt;
         tr_no_r    <= tr_no_nxt;
      end
   end

   // Read data register
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rd_r       <= 32'h0000_0000;
      end else begin
         rd_r       <= rd_nxt;
      end
   end

   // Outputs
   assign reg_rdata_out     = rd_r;
   assign pos_actual_out    = pos_r;
   assign quick_stop_out    = qs_r;
   assign limit_trip_out    = limit_hit | trip_pos | trip_neg;
   assign motor_stop_out    = limit_hit | trip_pos | trip_neg | qs_r;
   assign teach_accept_out  = tr_ok_r;
   assign teach_refused_out = tr_no_r;
endmodule : alm_axis_limit_monitor
`default_nettype wire

// ---- hdl/alm_pkg.sv ----
// Purpose: Shared constants for the axis limit monitor
// Assumes: Register port with 3-bit word index, 32-bit data
// Notes:   Offsets are word indices on the plain register port
package alm_pkg;
   localparam int unsigned ADDR_W = 3;
   // Register indices
   localparam logic [2:0] REG_STATUS    = 3'h0;
   localparam logic [2:0] REG_SOFT_POS  = 3'h1;
   localparam logic [2:0] REG_SOFT_NEG  = 3'h2;
   localparam logic [2:0] REG_SOFT_EN   = 3'h3;
   localparam logic [2:0] REG_IN_EN     = 3'h4;
   localparam logic [2:0] REG_IN_LEVEL  = 3'h5;
   localparam logic [2:0] REG_XMODE     = 3'h6;
   localparam logic [2:0] REG_ERROR     = 3'h7;
   // Status word bit positions
   localparam int unsigned ST_OVERRUN   = 2;
   localparam int unsigned ST_SOFT_POS  = 5;
   localparam int unsigned ST_SOFT_NEG  = 6;
   localparam int unsigned ST_HALT      = 7;
   localparam int unsigned ST_AMP_OFF   = 15;
   // Soft limit enable bits
   localparam int unsigned SE_POS       = 5;
   localparam int unsigned SE_NEG       = 6;
   // Extended mode status: referenced bit
   localparam int unsigned XM_REFERENCED = 5;
   // Input mask bit order
   localparam int unsigned IN_POSITIVE_LIMIT_INPUT      = 0;
   localparam int unsigned IN_NEGATIVE_LIMIT_INPUT      = 1;
   localparam int unsigned IN_STOP      = 2;
   localparam int unsigned IN_HOME      = 3;
   // Ends of the signed position range
   localparam logic [31:0] POS_MAX      = 32'h7FFF_FFFF;
   localparam logic [31:0] POS_MIN      = 32'h8000_0000;
   // Overrun fault code held in error memory
   localparam logic [19:0] FAULT_OVERRUN = 20'hE_181A;
   // Reset values
   localparam logic [31:0] SOFT_POS_RST = 32'h7FFF_FFFF;
   localparam logic [31:0] SOFT_NEG_RST = 32'h8000_0001;
   localparam logic [15:0] SOFT_EN_RST  = 16'h0000;
   localparam logic [3:0]  IN_EN_RST    = 4'h0;
   localparam logic [3:0]  IN_LEVEL_RST = 4'h0;
   // Operating modes
   typedef enum logic [1:0] {
      ALM_MODE_OTHER,
      ALM_MODE_PTP_ABS,
      ALM_MODE_PTP_REL,
      ALM_MODE_HOMING
   } alm_mode_t;
endpackage : alm_pkg

// ---- hdl/alm_sync.sv ----
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Single clock domain
// Notes:   First stage is read only by the second
`timescale 1ns/10ps
`default_nettype none
module alm_sync #(
   parameter int unsigned W = 4
) (
   input  wire logic         clk_in,
   input  wire logic         rst_b_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;

   // Two stage register chain
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= d_in;
         s2_r <= s1_r;
      end
   end
   assign q_out = s2_r;
endmodule : alm_sync
`default_nettype wire

// ---- sim/alm_assertions.sv ----
// Purpose: Port-level checks for the axis limit monitor
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound into every instance of the top module
`timescale 1ns/10ps
`default_nettype none
module alm_checker (
   input wire logic        clk_in,
   input wire logic        rst_b_in,
   input wire logic [2:0]  reg_addr_in,
   input wire logic        reg_rd_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic        pos_step_in,
   input wire logic        pos_dir_neg_in,
   input wire logic [1:0]  op_mode_in,
   input wire logic        moving_in,
   input wire logic        reference_done_in,
   input wire logic        new_move_cmd_in,
   input wire logic        amp_active_in,
   input wire logic        teach_req_in,
   input wire logic [31:0] pos_actual_out,
   input wire logic        motor_stop_out,
   input wire logic        quick_stop_out,
   input wire logic        limit_trip_out,
   input wire logic        teach_accept_out,
   input wire logic        teach_refused_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   // Position counting and wrap
   AST_STEP_UP: assert property (pos_step_in && !pos_dir_neg_in && !reference_done_in
      && pos_actual_out != 32'h7FFF_FFFF
      |=> pos_actual_out == $past(pos_actual_out) + 32'h0000_0001) else $error("bad up step");
   AST_STEP_DN: assert property (pos_step_in && pos_dir_neg_in && !reference_done_in
      && pos_actual_out != 32'h8000_0000
      |=> pos_actual_out == $past(pos_actual_out) - 32'h0000_0001) else $error("bad down step");
   AST_POS_HOLD: assert property (!pos_step_in && !reference_done_in
      |=> $stable(pos_actual_out)) else $error("position moved without step");
   AST_WRAP: assert property (pos_step_in && !pos_dir_neg_in && pos_actual_out == 32'h7FFF_FFFF
      && op_mode_in == alm_pkg::ALM_MODE_OTHER |=> pos_actual_out == 32'h8000_0000)
      else $error("no wrap at range end");
   AST_REL_ZERO: assert property (pos_step_in && !pos_dir_neg_in && pos_actual_out == 32'h7FFF_FFFF
      && op_mode_in == alm_pkg::ALM_MODE_PTP_REL |=> pos_actual_out == 32'h0000_0000)
      else $error("relative wrap not zeroed");
   // Status word contents
   AST_RESERVED: assert property (reg_rd_in && reg_addr_in == alm_pkg::REG_STATUS
      |=> (reg_rdata_out & 32'hFFFF_7F1B) == 32'h0000_0000) else $error("reserved bit set");
   AST_AMP_BIT: assert property (reg_rd_in && reg_addr_in == alm_pkg::REG_STATUS
      && $stable(amp_active_in) |=> reg_rdata_out[15] == !$past(amp_active_in))
      else $error("amplifier bit wrong");
   // Teach answer, stops
   AST_TEACH_ONE: assert property (teach_req_in
      |=> $onehot({teach_accept_out, teach_refused_out})) else $error("teach answer not single");
   AST_TEACH_QUIET: assert property (!teach_req_in
      |=> !teach_accept_out && !teach_refused_out) else $error("teach answer unasked");
   AST_QS_HOLD: assert property (quick_stop_out && !new_move_cmd_in
      |=> quick_stop_out) else $error("quick stop dropped early");
   AST_LIM_STOP: assert property (limit_trip_out && moving_in |-> motor_stop_out)
      else $error("limit trip without stop");
endmodule : alm_checker
bind alm_axis_limit_monitor alm_checker alm_checker_i (.*);
`default_nettype wire

// ---- sim/alm_far_model.sv ----
// Purpose: Switches and encoder feedback facing the monitor
// Assumes: Bench sets wanted pin levels and motion
// Notes:   All outputs change only after a rising edge
`timescale 1ns/10ps
`default_nettype none
module alm_far_model (
   input  wire logic       clk_in,
   input  wire logic       rst_b_in,
   input  wire logic [3:0] pin_req_in,
   input  wire logic       move_in,
   input  wire logic       dir_neg_in,
   output logic            pos_lim_out,
   output logic            neg_lim_out,
   output logic            stop_out,
   output logic            home_out,
   output logic            step_out,
   output logic            dir_neg_out
);
   // Raw switch levels, polarity judged by the monitor; one step per cycle while moving
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         {home_out, stop_out, neg_lim_out, pos_lim_out} <= 4'h0;
         {step_out, dir_neg_out} <= 2'h0;
      end else begin
         {home_out, stop_out, neg_lim_out, pos_lim_out} <= pin_req_in;
         {step_out, dir_neg_out} <= {move_in, dir_neg_in};
      end
   end
endmodule : alm_far_model
`default_nettype wire

// ---- sim/tb.sv ----
// Purpose: Self-checking bench for the axis limit monitor
// Assumes: 20 MHz clock, register reads answer next cycle
// Notes:   Referencing preloads the position next to the range end
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
   typedef struct packed {logic [31:0] sp; logic [15:0] en; logic amp; logic hlt;
      logic [31:0] ex;} alm_row_t;
   localparam alm_row_t ROWS [6] = '{'{32'h0000_0064, 16'h0020, 1, 0, 32'h0000_0020},
      '{32'h0000_0063, 16'h0020, 1, 0, 32'h0}, '{32'h0000_0064, 16'h0000, 1, 0, 32'h0},
      '{32'hFFFF_FF9C, 16'h0040, 1, 0, 32'h0000_0040}, '{32'hFFFF_FF9D, 16'h0060, 1, 0, 32'h0},
      '{32'h0000_0000, 16'h0060, 0, 1, 32'h0000_8080}};
   logic        clk_in = 0, rst_b_in = 0, wr = 0, rd = 0, mv = 0, dn = 0, mov = 1;
   logic        hlt = 0, amp = 1, step, dir, lp, ln, sp_pin, hp;
   logic        mstop, qstop, ltrip, tacc, tref;
   logic [1:0]  mode = '0;
   logic [2:0]  addr = '0;
   logic [3:0]  pins = '0, pl = '0;
   logic [31:0] wd = '0, rdata, pos, setp = '0, v;
   int          num_errors = 0, n_tests = 0, cyc = 0;
   alm_far_model alm_far_model_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .pin_req_in(pins),
      .move_in(mv), .dir_neg_in(dn), .pos_lim_out(lp), .neg_lim_out(ln), .stop_out(sp_pin),
      .home_out(hp), .step_out(step), .dir_neg_out(dir));
   alm_axis_limit_monitor alm_axis_limit_monitor_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .pos_step_in(step), .pos_dir_neg_in(dir), .pos_setpoint_in(setp), .op_mode_in(mode),
      .moving_in(mov), .reference_done_in(pl[3]), .new_move_cmd_in(pl[0]),
      .quick_stop_ack_in(pl[1]), .control_word_halt_in(hlt), .amp_active_in(amp),
      .teach_req_in(pl[2]), .positive_limit_input_in(lp), .negative_limit_input_in(ln),
      .stop_input_in(sp_pin), .home_switch_in(hp), .pos_actual_out(pos),
      .motor_stop_out(mstop), .quick_stop_out(qstop), .limit_trip_out(ltrip),
      .teach_accept_out(tacc), .teach_refused_out(tref));
   // Clock and hang guard
   always #25 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         close_out();
      end
   end
   task wreg(input logic [2:0] a, input logic [31:0] d);
      @(posedge clk_in) {addr, wd, wr} <= {a, d, 1'b1};
      @(posedge clk_in) wr <= 1'b0;
   endtask : wreg
   task rreg(input logic [2:0] a);
      @(posedge clk_in) {addr, rd} <= {a, 1'b1};
      @(posedge clk_in) rd <= 1'b0;
      #1 v = rdata;
   endtask : rreg
   task pulse(input logic [3:0] m);
      @(posedge clk_in) pl <= m;
      @(posedge clk_in) pl <= 4'h0;
      #1;
   endtask : pulse
   task settle();
      repeat (4) @(posedge clk_in);
      #1;
   endtask : settle
   task do_reset();
      @(posedge clk_in) rst_b_in <= 1'b0;
      repeat (10) @(posedge clk_in);
      rst_b_in <= 1'b1;
   endtask : do_reset
   task close_out();
      $display("tests=%0d errors=%0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : close_out
   // Main sequence
   initial begin
      do_reset();
      wreg(alm_pkg::REG_SOFT_POS, 32'h0000_0064);
      wreg(alm_pkg::REG_SOFT_NEG, 32'hFFFF_FF9C);
      foreach (ROWS[i]) begin
         @(posedge clk_in) {setp, amp, hlt} <= {ROWS[i].sp, ROWS[i].amp, ROWS[i].hlt};
         wreg(alm_pkg::REG_SOFT_EN, {16'h0, ROWS[i].en});
         rreg(alm_pkg::REG_STATUS);
         `CHK(v, ROWS[i].ex)
      end
      $display("end soft limit rows");
      @(posedge clk_in) {mv, dn} <= 2'b10;
      repeat (5) @(posedge clk_in);
      mv <= 1'b0;
      settle();
      `CHK(pos, 32'h0000_0005)
      @(posedge clk_in) {mv, dn} <= 2'b11;
      repeat (8) @(posedge clk_in);
      mv <= 1'b0;
      settle();
      `CHK(pos, 32'hFFFF_FFFD)
      $display("end position count");
      for (int i = 0; i < 2; i++) begin
         for (int k = 0; k < 8; k++) begin
            wreg(alm_pkg::REG_IN_EN, 32'(k & 1) << i);
            wreg(alm_pkg::REG_IN_LEVEL, 32'((k >> 1) & 1) << i);
            pins <= 4'((k >> 2) & 1) << i;
            settle();
            `CHK(ltrip, 1'(k == 1 || k == 7))
            `CHK(mstop, 1'(k == 1 || k == 7))
         end
      end
      @(posedge clk_in) mov <= 1'b0;
      settle();
      `CHK(ltrip, 1'b0)
      // Manual jog away from the tripped negative limit
      @(posedge clk_in) {mov, mv, dn, pins} <= {3'b110, 4'h0};
      settle();
      `CHK(ltrip, 1'b0)
      @(posedge clk_in) mv <= 1'b0;
      $display("end hardware limits");
      pins <= 4'h8;
      wreg(alm_pkg::REG_IN_EN, 32'h0000_000C);
      wreg(alm_pkg::REG_IN_LEVEL, 32'h0000_0004);
      pins <= 4'hC;
      settle();
      `CHK(qstop, 1'b1)
      pins <= 4'h8;
      settle();
      pulse(4'h1);
      settle();
      `CHK(qstop, 1'b1)
      pulse(4'h2);
      pulse(4'h1);
      settle();
      `CHK(qstop, 1'b0)
      $display("end stop input");
      pins <= 4'h0;
      settle();
      `CHK(qstop, 1'b1)
      pins <= 4'h8;
      settle();
      pulse(4'h2);
      pulse(4'h1);
      @(posedge clk_in) {mode, pins} <= {alm_pkg::ALM_MODE_HOMING, 4'h0};
      settle();
      `CHK(qstop, 1'b0)
      $display("end home switch");
      pulse(4'h4);
      `CHK({tacc, tref}, 2'b10)
      pulse(4'h8);
      wreg(alm_pkg::REG_STATUS, 32'hFFFF_FFFF);
      {setp, amp, hlt, mode} <= '0;
      @(posedge clk_in) amp <= 1'b1;
      rreg(alm_pkg::REG_STATUS);
      `CHK(v, 32'h0000_0000)
      $display("end teach and status write");
      do_reset();
      for (int i = 1; i < 6; i++) begin
         rreg(3'(i));
         `CHK(v, (i == 1) ? alm_pkg::SOFT_POS_RST : (i == 2) ? alm_pkg::SOFT_NEG_RST : 32'h0)
      end
      $display("end reset values");
      // Range end crossing in other, absolute and relative modes
      for (int m = 0; m < 3; m++) begin
         @(posedge clk_in) {mode, setp} <= {2'(m), 32'h7FFF_FFFE};
         pulse(4'h8);
         @(posedge clk_in) {mv, dn} <= 2'b10;
         repeat (3) @(posedge clk_in);
         mv <= 1'b0;
         settle();
         `CHK(pos, (m == 2) ? 32'h0000_0001 : 32'h8000_0001)
         rreg(alm_pkg::REG_STATUS);
         `CHK(v, (m == 1) ? 32'h0000_0000 : 32'h0000_0004)
         rreg(alm_pkg::REG_XMODE);
         `CHK(v, (m == 1) ? 32'h0000_0020 : 32'h0000_0000)
         rreg(alm_pkg::REG_ERROR);
         `CHK(v, (m == 1) ? 32'h0000_0000 : 32'h000E_181A)
         pulse(4'h4);
         `CHK({tacc, tref}, (m == 1) ? 2'b10 : 2'b01)
      end
      pulse(4'h8);
      rreg(alm_pkg::REG_STATUS);
      `CHK(v, 32'h0000_0000)
      $display("end range overrun");
      close_out();
   end
endmodule : tb
`default_nettype wire
